// [pkg/asrc_defs.vh]
// Constants for the acquisition run controller
`ifndef ASRC_DEFS_VH
`define ASRC_DEFS_VH
`define ASRC_ADDR_W 16
`define ASRC_DATA_W 32
`define ASRC_SMP_W 12
`define ASRC_MEM_AW 28
`define ASRC_SMP_MAX 12'hFFF
`define ASRC_TRIG_OFF 2'h0
`define ASRC_TRIG_ALWAYS 2'h1
`define ASRC_TRIG_SINGLE 2'h2
`define ASRC_CFG_BITS 16
`define ASRC_SPI_DIV 4'h3
`define ASRC_FIFO_DEPTH 16
`define ASRC_FIFO_AW 4
`endif

// [rtl/asrc_fifo.v]
// Parameterised synchronous FIFO with valid/ready on both sides
module asrc_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // Fill side
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  // Drain side
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push = in_valid_in && (count != DEPTH[AW:0]);
  wire pop = out_ready_in && (count != {(AW+1){1'b0}});
  assign in_ready_out = (count != DEPTH[AW:0]);
  assign out_valid_out = (count != {(AW+1){1'b0}});
  assign out_data_out = mem[rd_ptr];
  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// [rtl/asrc_top.v]
// Acquisition run controller: triggers, sample clock, capture, memory write, config
// How it works
// - Command bus: 16-bit address, 32-bit data
// - Host bridge reads memory and issues bus cycles
// - Run stores end minus start 12-bit samples
// - Run starts on trigger pin or host command
// - Two triggers, one selected: off/always/single
// - Makes sample clock, captures, writes memory
// - Static power enable and mux select held
// - SPI words set reference and test pattern
// - One of eight inputs via three muxes
// - Samples are unsigned 0 to 4095
// - Accepts samples up to 125 MHz
// - Reports trigger fired; trace stays readable
`include "asrc_defs.vh"
module asrc_top (
  // Clock and reset
  input wire mclk_in,
  input wire rst_in,
  // Host command bus (from the USB bridge)
  input wire bus_wr_in,
  input wire bus_rd_in,
  input wire [`ASRC_ADDR_W-1:0] bus_addr_in,
  input wire [`ASRC_DATA_W-1:0] bus_wdata_in,
  output reg [`ASRC_DATA_W-1:0] bus_rdata_out,
  output reg bus_rvalid_out,
  // Run configuration
  input wire [`ASRC_MEM_AW-1:0] start_addr_in,
  input wire [`ASRC_MEM_AW-1:0] end_addr_in,
  input wire trig_sel_in,
  input wire [1:0] trig_mode_in,
  input wire arm_in,
  input wire start_now_in,
  // Static front-end controls
  input wire pwr_en_in,
  input wire [2:0] mux_chan_in,
  output reg pwr_en_out,
  output reg [8:0] mux_en_out,
  // Converter configuration over SPI
  input wire cfg_go_in,
  input wire [`ASRC_CFG_BITS-1:0] cfg_word_in,
  output reg cfg_busy_out,
  output reg spi_sclk_out,
  output reg spi_mosi_out,
  output reg spi_cs_n_out,
  // Converter data and triggers (pins)
  input wire [1:0] trig_pin_in,
  input wire [`ASRC_SMP_W-1:0] adc_data_in,
  output reg adc_clk_out,
  // Memory write port
  output reg mem_wr_out,
  output reg [`ASRC_MEM_AW-1:0] mem_addr_out,
  output reg [`ASRC_SMP_W-1:0] mem_data_out,
  input wire mem_ready_in,
  // Status
  output reg trig_fired_out,
  output reg run_busy_out,
  output reg run_done_out,
  output reg overflow_out
);
  // One-hot run states: waiting, capturing, emptying the buffer
  localparam ST_IDLE = 3'b001;
  localparam ST_RUN = 3'b010;
  localparam ST_DRAIN = 3'b100;

  reg [2:0] state;
  reg [1:0] trig_s1;
  reg [1:0] trig_s2;
  reg trig_prev;
  reg [`ASRC_SMP_W-1:0] adc_s1;
  reg [`ASRC_SMP_W-1:0] adc_s2;
  reg armed;
  reg [`ASRC_MEM_AW-1:0] cap_left;
  reg [`ASRC_MEM_AW-1:0] wr_addr;
  reg [`ASRC_MEM_AW-1:0] run_end;
  reg [`ASRC_DATA_W-1:0] scratch;
  reg [3:0] spi_div;
  reg [4:0] spi_cnt;
  reg [`ASRC_CFG_BITS-1:0] spi_sh;

  // Trigger path: two flops, then a rising-edge detect on the selected pin.
  // A pulse shorter than one clock may be missed; the source must hold it longer.
  wire trig_lvl = trig_sel_in ? trig_s2[1] : trig_s2[0];
  wire trig_edge = trig_lvl && !trig_prev;
  wire trig_ok = (trig_mode_in == `ASRC_TRIG_ALWAYS) ||
                 ((trig_mode_in == `ASRC_TRIG_SINGLE) && armed);
  wire start_run = (state == ST_IDLE) &&
                   ((trig_edge && trig_ok) || start_now_in);
  // One sample per sample-clock period; capture stops once the run count is spent
  wire smp_take = (state == ST_RUN) && adc_clk_out && (cap_left != {`ASRC_MEM_AW{1'b0}});
  wire fifo_in_ready;
  wire fifo_valid;
  wire [`ASRC_SMP_W-1:0] fifo_data;
  // A word leaves the buffer only when the write port is free or being accepted
  wire fifo_pop = fifo_valid && (!mem_wr_out || mem_ready_in);
  // Status word: write pointer over busy, done, fired and overflow flags.
  // The pointer fills the top 28 bits, so no spare bits remain above it.
  wire [`ASRC_DATA_W-1:0] status_word = {wr_addr, run_busy_out, run_done_out,
    trig_fired_out, overflow_out};

  // Samples buffered so memory stalls do not drop data immediately
  asrc_fifo #(
    .WIDTH(`ASRC_SMP_W),
    .DEPTH(`ASRC_FIFO_DEPTH),
    .AW(`ASRC_FIFO_AW)
  ) u_fifo (
    .clk_in(mclk_in),
    .rst_in(rst_in),
    .in_valid_in(smp_take),
    .in_ready_out(fifo_in_ready),
    .in_data_in(adc_s2),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop),
    .out_data_out(fifo_data)
  );

  // Pin synchronisers
  // The converter changes its code once per sample-clock period, two system
  // cycles, so the take reads a word that has stood steady for a cycle.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      trig_s1 <= 2'h0;
      trig_s2 <= 2'h0;
      adc_s1 <= 12'h000;
      adc_s2 <= 12'h000;
      trig_prev <= 1'b0;
    end else begin
      trig_s1 <= trig_pin_in;
      trig_s2 <= trig_s1;
      adc_s1 <= adc_data_in;
      adc_s2 <= adc_s1;
      trig_prev <= trig_lvl;
    end
  end

  // Run sequencing
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= ST_IDLE;
      armed <= 1'b0;
      cap_left <= {`ASRC_MEM_AW{1'b0}};
      run_end <= {`ASRC_MEM_AW{1'b0}};
      adc_clk_out <= 1'b0;
      trig_fired_out <= 1'b0;
      run_busy_out <= 1'b0;
      run_done_out <= 1'b0;
      overflow_out <= 1'b0;
    end else begin
      if (arm_in) begin
        armed <= 1'b1;
        trig_fired_out <= 1'b0;
      end
      // Sample clock at half the system rate; one capture per period
      adc_clk_out <= (state == ST_RUN) ? !adc_clk_out : 1'b0;
      if (smp_take && !fifo_in_ready) begin
        overflow_out <= 1'b1;
      end
      // A sample that meets a full buffer is lost and flagged; the run still
      // ends on its count, but a stalled memory keeps the sequencer waiting in ST_DRAIN.
      case (state)
        ST_IDLE: begin
          if (start_run) begin
            state <= ST_RUN;
            // Length fixed at start; later address changes do not touch this run
            cap_left <= end_addr_in - start_addr_in;
            run_end <= end_addr_in;
            run_busy_out <= 1'b1;
            run_done_out <= 1'b0;
            overflow_out <= 1'b0;
            if (!start_now_in) begin
              trig_fired_out <= 1'b1;
              if (trig_mode_in == `ASRC_TRIG_SINGLE) begin
                armed <= arm_in;
              end
            end
          end
        end
        ST_RUN: begin
          // Leaves on the last take, or at once for a zero-length run
          if (smp_take) begin
            cap_left <= cap_left - 1'b1;
          end
          if (cap_left == {`ASRC_MEM_AW{1'b0}} ||
              (smp_take && cap_left == {{(`ASRC_MEM_AW-1){1'b0}}, 1'b1})) begin
            state <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          // Done only after the last buffered word has been accepted by memory
          if (!fifo_valid && (!mem_wr_out || mem_ready_in)) begin
            state <= ST_IDLE;
            run_busy_out <= 1'b0;
            run_done_out <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Memory writer
  // The write request stands until the memory accepts it; the next word may
  // replace it on the accepting edge, so a ready memory takes one word a cycle.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_wr_out <= 1'b0;
      mem_addr_out <= {`ASRC_MEM_AW{1'b0}};
      mem_data_out <= 12'h000;
      wr_addr <= {`ASRC_MEM_AW{1'b0}};
    end else begin
      if (start_run) begin
        wr_addr <= start_addr_in;
      end else if (fifo_pop && wr_addr != run_end) begin
        mem_wr_out <= 1'b1;
        mem_addr_out <= wr_addr;
        mem_data_out <= fifo_data;
        wr_addr <= wr_addr + 1'b1;
      end else if (mem_ready_in) begin
        mem_wr_out <= 1'b0;
      end
    end
  end

  // Static controls and host command bus
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pwr_en_out <= 1'b0;
      mux_en_out <= 9'h000;
      scratch <= 32'h00000000;
      bus_rdata_out <= 32'h00000000;
      bus_rvalid_out <= 1'b0;
    end else begin
      // Levels are registered once so the pins come straight from flops
      pwr_en_out <= pwr_en_in;
      // Channel 0..7 maps to mux (c/3) input (c%3); only one enable high
      mux_en_out <= 9'h001 << mux_chan_in;
      if (bus_wr_in) begin
        scratch <= bus_wdata_in;
      end
      bus_rvalid_out <= bus_rd_in;
      if (bus_rd_in) begin
        // Address zero is a scratch word; any other address reads the run status
        bus_rdata_out <= (bus_addr_in == 16'h0000) ? scratch : status_word;
      end
    end
  end

  // SPI configuration shifter, mode 0, MSB first
  // Each half clock period lasts the divider count plus one system cycles;
  // select stays low for the whole 16-bit frame and a request during it is ignored.
  always @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      spi_div <= 4'h0;
      spi_cnt <= 5'h00;
      spi_sh <= 16'h0000;
      cfg_busy_out <= 1'b0;
      spi_sclk_out <= 1'b0;
      spi_mosi_out <= 1'b0;
      spi_cs_n_out <= 1'b1;
    end else if (!cfg_busy_out) begin
      if (cfg_go_in) begin
        cfg_busy_out <= 1'b1;
        spi_cs_n_out <= 1'b0;
        spi_mosi_out <= cfg_word_in[`ASRC_CFG_BITS-1];
        spi_sh <= {cfg_word_in[`ASRC_CFG_BITS-2:0], 1'b0};
        spi_cnt <= 5'h10;
        spi_div <= 4'h0;
      end
    end else if (spi_div != `ASRC_SPI_DIV) begin
      spi_div <= spi_div + 1'b1;
    end else begin
      spi_div <= 4'h0;
      if (!spi_sclk_out) begin
        spi_sclk_out <= 1'b1;
        spi_cnt <= spi_cnt - 1'b1;
      end else begin
        spi_sclk_out <= 1'b0;
        if (spi_cnt == 5'h00) begin
          cfg_busy_out <= 1'b0;
          spi_cs_n_out <= 1'b1;
        end else begin
          spi_mosi_out <= spi_sh[`ASRC_CFG_BITS-1];
          spi_sh <= {spi_sh[`ASRC_CFG_BITS-2:0], 1'b0};
        end
      end
    end
  end
endmodule

// [bench/asrc_adc_model.sv]
// Behavioural parallel-output converter model
module asrc_adc_model (
  input wire logic adc_clk_in,
  output logic [11:0] adc_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Starts near full scale so the code wraps from 4095 to 0 early
  initial adc_data_out = 12'hFFD;
  always @(posedge adc_clk_in) adc_data_out <= adc_data_out + 12'h001;
endmodule

// [bench/asrc_top_asserts.sv]
// Port checker for the acquisition run controller
module asrc_top_asserts (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic pwr_en_in,
  input wire logic [2:0] mux_chan_in,
  input wire logic pwr_en_out,
  input wire logic [8:0] mux_en_out,
  input wire logic cfg_go_in,
  input wire logic cfg_busy_out,
  input wire logic spi_cs_n_out,
  input wire logic start_now_in,
  input wire logic [27:0] start_addr_in,
  input wire logic [27:0] end_addr_in,
  input wire logic mem_wr_out,
  input wire logic [27:0] mem_addr_out,
  input wire logic [11:0] mem_data_out,
  input wire logic mem_ready_in,
  input wire logic run_busy_out,
  input wire logic run_done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_stall;
    mem_wr_out && !mem_ready_in;
  endsequence
  sequence s_frame_end;
    ##[100:200] $rose(spi_cs_n_out);
  endsequence
  a_pwr_follow: assert property ($stable(pwr_en_in) && !$past(rst_in)
    |-> pwr_en_out == pwr_en_in) else $error("power enable not held");
  a_mux_onehot: assert property ($stable(mux_chan_in) && !$past(rst_in)
    |-> mux_en_out == 9'h001 << mux_chan_in) else $error("mux enable wrong");
  a_run_answer: assert property (start_now_in && !run_busy_out |=> run_busy_out)
    else $error("host start ignored");
  a_done_end: assert property ($fell(run_busy_out) |-> run_done_out)
    else $error("run ended without done");
  a_wr_hold: assert property (s_stall |=> mem_wr_out && $stable(mem_addr_out)
    && $stable(mem_data_out)) else $error("write dropped while stalled");
  a_addr_range: assert property (mem_wr_out |-> mem_addr_out >= start_addr_in
    && mem_addr_out < end_addr_in) else $error("write outside run window");
  a_cfg_take: assert property (cfg_go_in && !cfg_busy_out |=> cfg_busy_out)
    else $error("config request ignored");
  a_cs_busy: assert property (!spi_cs_n_out |-> cfg_busy_out)
    else $error("select low while idle");
  a_spi_frame: assert property ($fell(spi_cs_n_out) |-> s_frame_end)
    else $error("config frame length wrong");
endmodule
bind asrc_top asrc_top_asserts u_chk (.*);

// [bench/adc_sampling_run_controller_tb_top.sv]
// Self-checking bench for the acquisition run controller
`include "asrc_defs.vh"
module adc_sampling_run_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 0, rst_in = 1, bus_wr_in = 0, bus_rd_in = 0, trig_sel_in = 0, stall = 0;
  logic arm_in = 0, start_now_in = 0, pwr_en_in = 0, cfg_go_in = 0, mem_ready_in = 0;
  logic pwr_en_out, bus_rvalid_out, cfg_busy_out, spi_sclk_out, spi_mosi_out, spi_cs_n_out;
  logic adc_clk_out, mem_wr_out, trig_fired_out, run_busy_out, run_done_out, overflow_out;
  logic [15:0] bus_addr_in = 16'h0000, cfg_word_in = 16'h0000;
  logic [31:0] bus_wdata_in = 32'h0, bus_rdata_out;
  logic [27:0] start_addr_in = 28'h0, end_addr_in = 28'h0, mem_addr_out, wr_first, wr_prev;
  logic [1:0] trig_mode_in = 2'h0, trig_pin_in = 2'h0;
  logic [2:0] mux_chan_in = 3'h0;
  logic [8:0] mux_en_out;
  logic [11:0] adc_data_in, mem_data_out, dat_prev;
  int num_errors = 0, checks_done = 0, wr_cnt = 0, cycles = 0;
  asrc_top DUT (.*);
  asrc_adc_model u_adc (.adc_clk_in(adc_clk_out), .adc_data_out(adc_data_in));
  always #4 mclk_in = ~mclk_in;
  // Slow memory: ready every other cycle, so the FIFO sees back-pressure
  always @(negedge mclk_in) mem_ready_in <= !stall && !mem_ready_in;
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      close_out;
    end
    if ((mem_wr_out && mem_ready_in) === 1'b1) begin
      if (wr_cnt == 0) wr_first = mem_addr_out;
      else begin
        cmp("mem_addr", wr_prev + 28'h1, mem_addr_out);
        if (overflow_out === 1'b0) cmp("mem_data", 12'(dat_prev + 12'h1), mem_data_out);
      end
      wr_prev = mem_addr_out;
      dat_prev = mem_data_out;
      wr_cnt++;
    end
  end
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Write, or read and compare masked data against d
  task automatic bus(logic wr, logic [15:0] a, logic [31:0] d, logic [31:0] m);
    bus_wr_in = wr;
    bus_rd_in = !wr;
    bus_addr_in = a;
    bus_wdata_in = d;
    tick;
    bus_wr_in = 0;
    bus_rd_in = 0;
    if (!wr) cmp("rvalid", 1'h1, bus_rvalid_out);
    if (!wr) cmp("rdata", d, bus_rdata_out & m);
    tick;
  endtask
  task automatic expect_run(logic e);
    int i;
    for (i = 0; i < 12 && run_busy_out !== 1'b1; i++) tick;
    cmp("run_busy", e, run_busy_out);
    if (e) begin
      for (i = 0; i < 3000 && run_busy_out !== 1'b0; i++) tick;
      cmp("run_done", 1'h1, run_done_out);
      cmp("wr_count", end_addr_in - start_addr_in, wr_cnt);
      cmp("wr_first", start_addr_in, wr_first);
    end
  endtask
  task automatic host_run(logic [27:0] s, logic [27:0] n);
    wr_cnt = 0;
    start_addr_in = s;
    end_addr_in = s + n;
    start_now_in = 1;
    tick;
    start_now_in = 0;
    expect_run(1'h1);
  endtask
  task automatic fire(int k, logic e);
    wr_cnt = 0;
    trig_pin_in[k] = 1;
    tick(4);
    trig_pin_in[k] = 0;
    expect_run(e);
  endtask
  task automatic t_static;
    for (int c = 0; c < 8; c++) begin
      mux_chan_in = c[2:0];
      pwr_en_in = c[0];
      tick(2);
      cmp("mux_en", 9'h001 << c, mux_en_out);
      cmp("pwr_en", c[0], pwr_en_out);
    end
  endtask
  task automatic t_trig;
    trig_sel_in = 1;
    trig_mode_in = `ASRC_TRIG_OFF;
    fire(1, 1'h0);
    trig_mode_in = `ASRC_TRIG_SINGLE;
    fire(1, 1'h0);
    arm_in = 1;
    tick;
    arm_in = 0;
    fire(0, 1'h0);
    fire(1, 1'h1);
    cmp("fired", 1'h1, trig_fired_out);
    fire(1, 1'h0);
    trig_mode_in = `ASRC_TRIG_ALWAYS;
    fire(1, 1'h1);
    fire(1, 1'h1);
  endtask
  task automatic t_spi;
    logic [15:0] got;
    cfg_word_in = 16'hC35A;
    cfg_go_in = 1;
    tick;
    cfg_go_in = 0;
    repeat (16) begin
      @(posedge spi_sclk_out);
      got = {got[14:0], spi_mosi_out};
    end
    @(posedge spi_cs_n_out);
    tick(2);
    cmp("spi_word", 16'hC35A, got);
    cmp("cfg_busy", 1'h0, cfg_busy_out);
  endtask
  // FIFO fills while memory stalls; overflow must show, run must still end
  task automatic t_ovf;
    stall = 1;
    wr_cnt = 0;
    start_addr_in = 28'h0000200;
    end_addr_in = 28'h0000240;
    start_now_in = 1;
    tick;
    start_now_in = 0;
    tick(120);
    cmp("overflow", 1'h1, overflow_out);
    cmp("wr_held", 1'h1, mem_wr_out);
    stall = 0;
    tick(400);
    cmp("busy_end", 1'h0, run_busy_out);
  endtask
  initial begin
    tick(8);
    cmp("cs_rst", 1'h1, spi_cs_n_out);
    cmp("busy_rst", 1'h0, run_busy_out);
    rst_in = 0;
    tick;
    t_static;
    bus(1, 16'h0000, 32'hA5C30FF0, 32'h0);
    bus(0, 16'h0000, 32'hA5C30FF0, 32'hFFFFFFFF);
    host_run(28'h0000100, 28'h0000005);
    cmp("fired_host", 1'h0, trig_fired_out);
    t_trig;
    t_spi;
    t_ovf;
    bus(0, 16'h0004, 32'h5, 32'hD);
    close_out;
  end
endmodule
